/* include/dcr_pkg.sv */
package dcr_pkg;

    // Register bus widths.
    localparam int DCR_ADDR_W = 8;
    localparam int DCR_DATA_W = 16;

    // Register byte addresses.
    localparam logic [7:0] DCR_DEV_CTL_ADDR = 8'h98;
    localparam logic [7:0] DCR_CLS_ADDR = 8'h0c;
    localparam logic [7:0] DCR_INT_STATUS_ADDR = 8'he0;
    localparam logic [7:0] DCR_INT_MASK_ADDR = 8'he4;

    // Device control register reset value.
    localparam logic [15:0] DCR_DEV_CTL_RESET = 16'h2800;

    // Device control field positions.
    localparam int DCR_RETRY_BIT = 15;
    localparam int DCR_MAX_READ_REQ_SIZE_HI = 14;
    localparam int DCR_MAX_READ_REQ_SIZE_LO = 12;
    localparam int DCR_NO_SNOOP_BIT = 11;
    localparam int DCR_AUX_PM_BIT = 10;
    localparam int DCR_PHANTOM_BIT = 9;
    localparam int DCR_EXT_TAG_BIT = 8;
    localparam int DCR_MPS_HI = 7;
    localparam int DCR_MPS_LO = 5;
    localparam int DCR_RELAXED_BIT = 4;
    localparam int DCR_UR_REPORT_BIT = 3;
    localparam int DCR_FATAL_REPORT_BIT = 2;
    localparam int DCR_NONFATAL_REPORT_BIT = 1;
    localparam int DCR_CORR_REPORT_BIT = 0;

    // Writable bits of the device control register.
    localparam logic [15:0] DCR_DEV_CTL_WMASK = 16'hfcef;

    // Cache line size register width and reset value.
    localparam int DCR_CLS_W = 8;
    localparam logic [7:0] DCR_CLS_RESET = 8'h00;

    // Interrupt status bit positions.
    localparam int DCR_INT_W = 5;
    localparam int DCR_INT_CORR = 0;
    localparam int DCR_INT_NONFATAL = 1;
    localparam int DCR_INT_FATAL = 2;
    localparam int DCR_INT_UR = 3;
    localparam int DCR_INT_CFG_TIMEOUT = 4;
    localparam logic [4:0] DCR_INT_RESET = 5'h00;

    // Size encodings: 128 bytes shifted by the code, codes above 5 reserved.
    localparam int DCR_BYTES_W = 13;
    localparam logic [12:0] DCR_MIN_BYTES = 13'h0080;
    localparam logic [2:0] DCR_MAX_SIZE_CODE = 3'h5;

    // Converts a size code to bytes; reserved codes give the largest size.
    function automatic logic [12:0] dcr_size_bytes(input logic [2:0] code);
        logic [2:0] c;
        c = (code > DCR_MAX_SIZE_CODE) ? DCR_MAX_SIZE_CODE : code;
        return DCR_MIN_BYTES << c;
    endfunction : dcr_size_bytes

endpackage : dcr_pkg

/* verilog/dcr_size_decode.sv */
module dcr_size_decode
    import dcr_pkg::*;
(
    input wire logic [2:0] max_read_req_size,
    input wire logic [2:0] max_payload_size,
    input wire logic [DCR_CLS_W-1:0] cache_line_dwords,
    output logic [DCR_BYTES_W-1:0] read_req_bytes,
    output logic [DCR_BYTES_W-1:0] payload_bytes,
    output logic [DCR_BYTES_W-1:0] prefetch_bytes
);

    logic [DCR_BYTES_W-1:0] line_bytes;

    // Cache line size counts dwords, so four bytes per unit.
    assign line_bytes = {3'h0, cache_line_dwords, 2'h0};

    // Both size fields share one decode; reserved codes count as 4096 bytes.
    assign read_req_bytes = dcr_size_bytes(max_read_req_size);
    assign payload_bytes = dcr_size_bytes(max_payload_size);

    // Prefetch one cache line when it is set and shorter than the request cap,
    // otherwise the whole request cap; an unset line size means no hint.
    always_comb begin
        if (line_bytes != '0 && line_bytes < read_req_bytes) begin
            prefetch_bytes = line_bytes;
        end else begin
            prefetch_bytes = read_req_bytes;
        end
    end

endmodule : dcr_size_decode

/* verilog/dcr_device_control.sv */
// What this block does
// - Retry-status completion on forwarded config timeout only when retry enable set; resets 0.
// - Read request size field bits 14:12 caps each read request; default 512 bytes.
// - Prefetch amount per read combines read request cap with cache line size.
// - Bit 11 gives no-snoop attribute for upstream memory traffic off VC0; resets 1.
// - Aux power enable bit is plain storage, default 0, with no effect.
// - Phantom function, extended tag and relaxed ordering bits read 0, ignore writes.
// - Payload size field bits 7:5 caps posted writes and completions; default 128.
// - Unsupported request sends nonfatal message only while its report bit is set.
// - Fatal events send fatal messages only while fatal report bit is set.
// - Nonfatal events send nonfatal messages only while nonfatal report bit set.
// - Correctable events send correctable messages only while report bit set.
// - Device control sits at offset 98h and resets to 2800h.
module dcr_device_control
    import dcr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [DCR_ADDR_W-1:0] reg_addr,
    input wire logic [DCR_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DCR_DATA_W-1:0] reg_rdata,
    input wire logic cfg_fwd_timeout,
    input wire logic unsupp_req_rcvd,
    input wire logic fatal_err_event,
    input wire logic nonfatal_err_event,
    input wire logic corr_err_event,
    input wire logic upstream_vc_nonzero,
    output logic cfg_retry_cpl_send,
    output logic err_fatal_msg_send,
    output logic err_nonfatal_msg_send,
    output logic err_cor_msg_send,
    output logic tlp_no_snoop,
    output logic [DCR_BYTES_W-1:0] read_req_limit_bytes,
    output logic [DCR_BYTES_W-1:0] payload_limit_bytes,
    output logic [DCR_BYTES_W-1:0] read_prefetch_bytes,
    output logic aux_power_pm_en,
    output logic irq
);

    // All block state in one record.
    typedef struct packed {
        logic [DCR_DATA_W-1:0] dev_ctl;
        logic [DCR_CLS_W-1:0] cache_line;
        logic [DCR_INT_W-1:0] int_status;
        logic [DCR_INT_W-1:0] int_mask;
        logic [DCR_DATA_W-1:0] rdata;
        logic retry_cpl;
        logic fatal_msg;
        logic nonfatal_msg;
        logic cor_msg;
        logic no_snoop;
        logic [DCR_BYTES_W-1:0] read_req_bytes;
        logic [DCR_BYTES_W-1:0] payload_bytes;
        logic [DCR_BYTES_W-1:0] prefetch_bytes;
    } dcr_state_type;

    dcr_state_type state;
    dcr_state_type next_state;

    logic [DCR_BYTES_W-1:0] dec_read_req_bytes;
    logic [DCR_BYTES_W-1:0] dec_payload_bytes;
    logic [DCR_BYTES_W-1:0] dec_prefetch_bytes;
    logic [DCR_INT_W-1:0] int_events;
    logic [DCR_INT_W-1:0] int_clear;

    // Named views of the stored control fields.
    logic cfg_retry_completion_en;
    logic [2:0] max_read_req_size;
    logic no_snoop_flag_en;
    logic [2:0] max_payload_size;
    logic unsupp_req_report_en;
    logic fatal_err_report_en;
    logic nonfatal_err_report_en;
    logic corr_err_report_en;

    assign cfg_retry_completion_en = state.dev_ctl[DCR_RETRY_BIT];
    assign max_read_req_size = state.dev_ctl[DCR_MAX_READ_REQ_SIZE_HI:DCR_MAX_READ_REQ_SIZE_LO];
    assign no_snoop_flag_en = state.dev_ctl[DCR_NO_SNOOP_BIT];
    assign max_payload_size = state.dev_ctl[DCR_MPS_HI:DCR_MPS_LO];
    assign unsupp_req_report_en = state.dev_ctl[DCR_UR_REPORT_BIT];
    assign fatal_err_report_en = state.dev_ctl[DCR_FATAL_REPORT_BIT];
    assign nonfatal_err_report_en = state.dev_ctl[DCR_NONFATAL_REPORT_BIT];
    assign corr_err_report_en = state.dev_ctl[DCR_CORR_REPORT_BIT];

    // Limit reset values go through the same decode as the fields, so a changed
    // control default cannot leave the limits out of step. Prefetch starts equal to
    // the read limit because the cache line size resets to zero.
    localparam logic [DCR_BYTES_W-1:0] READ_REQ_RESET =
        dcr_size_bytes(DCR_DEV_CTL_RESET[DCR_MAX_READ_REQ_SIZE_HI:DCR_MAX_READ_REQ_SIZE_LO]);
    localparam logic [DCR_BYTES_W-1:0] PAYLOAD_RESET =
        dcr_size_bytes(DCR_DEV_CTL_RESET[DCR_MPS_HI:DCR_MPS_LO]);

    // One address decode shared by the write and clear strobes, so those two paths
    // can never disagree on where a register lives; reads decode in read_word.
    function automatic logic reg_hit(
        input logic strobe,
        input logic [DCR_ADDR_W-1:0] addr,
        input logic [DCR_ADDR_W-1:0] target
    );
        return strobe && (addr == target);
    endfunction : reg_hit

    // Read multiplexer; unmapped addresses read zero, so probing software sees
    // nothing rather than a stale word.
    function automatic logic [DCR_DATA_W-1:0] read_word(
        input logic [DCR_ADDR_W-1:0] addr,
        input logic [DCR_DATA_W-1:0] dev_ctl,
        input logic [DCR_CLS_W-1:0] cache_line,
        input logic [DCR_INT_W-1:0] int_status,
        input logic [DCR_INT_W-1:0] int_mask
    );
        logic [DCR_DATA_W-1:0] word;
        word = '0;
        case (addr)
            DCR_DEV_CTL_ADDR: word = dev_ctl;
            DCR_CLS_ADDR: word[DCR_CLS_W-1:0] = cache_line;
            DCR_INT_STATUS_ADDR: word[DCR_INT_W-1:0] = int_status;
            DCR_INT_MASK_ADDR: word[DCR_INT_W-1:0] = int_mask;
            default: word = '0;
        endcase
        return word;
    endfunction : read_word

    // A message leaves only when its event meets its enable. The status bits do not
    // depend on the enables, so software can still poll what was suppressed.
    function automatic logic gated(
        input logic event_seen,
        input logic report_en
    );
        return event_seen & report_en;
    endfunction : gated

    // Size decode and prefetch sizing; its results are registered below.
    dcr_size_decode u_size_decode (
        .max_read_req_size(max_read_req_size),
        .max_payload_size(max_payload_size),
        .cache_line_dwords(state.cache_line),
        .read_req_bytes(dec_read_req_bytes),
        .payload_bytes(dec_payload_bytes),
        .prefetch_bytes(dec_prefetch_bytes)
    );

    // Raw events feeding the sticky status bits, independent of report enables.
    always_comb begin
        int_events = '0;
        int_events[DCR_INT_CORR] = corr_err_event;
        int_events[DCR_INT_NONFATAL] = nonfatal_err_event;
        int_events[DCR_INT_FATAL] = fatal_err_event;
        int_events[DCR_INT_UR] = unsupp_req_rcvd;
        int_events[DCR_INT_CFG_TIMEOUT] = cfg_fwd_timeout;
    end

    // Write-one-to-clear mask for the status register.
    assign int_clear = reg_hit(reg_write, reg_addr, DCR_INT_STATUS_ADDR) ? reg_wdata[DCR_INT_W-1:0] : '0;

    // Sticky status, one bit per event; the event beats a clear in the same cycle,
    // otherwise an event arriving while software clears the bit would be lost.
    logic [DCR_INT_W-1:0] status_kept;
    for (genvar i = 0; i < DCR_INT_W; i++) begin : g_status
        assign status_kept[i] = (state.int_status[i] & ~int_clear[i]) | int_events[i];
    end

    // Next-state logic for registers, messages and derived limits.
    always_comb begin
        next_state = state;

        // Only the writable bits take the write; hardwired zeros stay zero.
        if (reg_hit(reg_write, reg_addr, DCR_DEV_CTL_ADDR)) begin
            next_state.dev_ctl = reg_wdata & DCR_DEV_CTL_WMASK;
        end
        if (reg_hit(reg_write, reg_addr, DCR_CLS_ADDR)) begin
            next_state.cache_line = reg_wdata[DCR_CLS_W-1:0];
        end
        if (reg_hit(reg_write, reg_addr, DCR_INT_MASK_ADDR)) begin
            next_state.int_mask = reg_wdata[DCR_INT_W-1:0];
        end

        // A new event in the same cycle as its clear keeps the bit set.
        next_state.int_status = status_kept;

        // Read data is valid only in the cycle after the read strobe.
        next_state.rdata = '0;
        if (reg_read) begin
            next_state.rdata = read_word(reg_addr, state.dev_ctl, state.cache_line, state.int_status,
                state.int_mask);
        end

        // With retry disabled a timeout never yields a retry-status completion.
        next_state.retry_cpl = gated(cfg_fwd_timeout, cfg_retry_completion_en);

        // Error messages follow their events one cycle later, gated by the enables.
        next_state.fatal_msg = gated(fatal_err_event, fatal_err_report_en);
        next_state.nonfatal_msg = gated(nonfatal_err_event, nonfatal_err_report_en)
            | gated(unsupp_req_rcvd, unsupp_req_report_en);
        next_state.cor_msg = gated(corr_err_event, corr_err_report_en);

        // VC0 traffic always carries a clear no-snoop attribute.
        next_state.no_snoop = gated(upstream_vc_nonzero, no_snoop_flag_en);

        // Limits lag a control write by one cycle, which keeps them glitch free.
        next_state.read_req_bytes = dec_read_req_bytes;
        next_state.payload_bytes = dec_payload_bytes;
        next_state.prefetch_bytes = dec_prefetch_bytes;
    end

    // State register; reset values match the documented field defaults.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state.dev_ctl <= DCR_DEV_CTL_RESET;
            state.cache_line <= DCR_CLS_RESET;
            state.int_status <= DCR_INT_RESET;
            state.int_mask <= DCR_INT_RESET;
            state.rdata <= '0;
            state.retry_cpl <= 1'b0;
            state.fatal_msg <= 1'b0;
            state.nonfatal_msg <= 1'b0;
            state.cor_msg <= 1'b0;
            state.no_snoop <= 1'b0;
            state.read_req_bytes <= READ_REQ_RESET;
            state.payload_bytes <= PAYLOAD_RESET;
            state.prefetch_bytes <= READ_REQ_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state record, except the level interrupt.
    assign reg_rdata = state.rdata;
    assign cfg_retry_cpl_send = state.retry_cpl;
    assign err_fatal_msg_send = state.fatal_msg;
    assign err_nonfatal_msg_send = state.nonfatal_msg;
    assign err_cor_msg_send = state.cor_msg;
    assign tlp_no_snoop = state.no_snoop;
    assign read_req_limit_bytes = state.read_req_bytes;
    assign payload_limit_bytes = state.payload_bytes;
    assign read_prefetch_bytes = state.prefetch_bytes;
    assign aux_power_pm_en = state.dev_ctl[DCR_AUX_PM_BIT];
    assign irq = |(state.int_status & state.int_mask);

endmodule : dcr_device_control

/* tb/dcr_rc_model.sv */
// Root complex side: counts every message the endpoint sends upstream.
module dcr_rc_model
    import dcr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cfg_retry_cpl_send,
    input wire logic err_fatal_msg_send,
    input wire logic err_nonfatal_msg_send,
    input wire logic err_cor_msg_send,
    output logic [7:0] n_msg
);
    // A message is one pulse per cycle, so each high cycle is one message.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            n_msg <= 8'h00;
        end else begin
            n_msg <= n_msg + 8'(cfg_retry_cpl_send) + 8'(err_fatal_msg_send)
                + 8'(err_nonfatal_msg_send) + 8'(err_cor_msg_send);
        end
    end
endmodule : dcr_rc_model

/* tb/dcr_checker.sv */
// Port-level relations of the device control block.
module dcr_checker
    import dcr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [DCR_ADDR_W-1:0] reg_addr,
    input wire logic [DCR_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DCR_DATA_W-1:0] reg_rdata,
    input wire logic cfg_fwd_timeout,
    input wire logic unsupp_req_rcvd,
    input wire logic fatal_err_event,
    input wire logic nonfatal_err_event,
    input wire logic corr_err_event,
    input wire logic upstream_vc_nonzero,
    input wire logic cfg_retry_cpl_send,
    input wire logic err_fatal_msg_send,
    input wire logic err_nonfatal_msg_send,
    input wire logic err_cor_msg_send,
    input wire logic tlp_no_snoop,
    input wire logic [DCR_BYTES_W-1:0] read_req_limit_bytes,
    input wire logic [DCR_BYTES_W-1:0] payload_limit_bytes,
    input wire logic [DCR_BYTES_W-1:0] read_prefetch_bytes,
    input wire logic aux_power_pm_en
);
    // Every check shares the core clock and reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Shadow of the control register built from its reset value and writable bits,
    // so the checks below also catch a message that escapes a cleared enable.
    logic [DCR_DATA_W-1:0] ctl_model;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_model <= DCR_DEV_CTL_RESET;
        end else if (reg_write && reg_addr == DCR_DEV_CTL_ADDR) begin
            ctl_model <= reg_wdata & DCR_DEV_CTL_WMASK;
        end
    end
    a_retry_cause: assert property (cfg_retry_cpl_send |->
        $past(cfg_fwd_timeout && ctl_model[DCR_RETRY_BIT]))
        else $error("retry completion without an enabled timeout");
    a_retry_send: assert property (cfg_fwd_timeout && ctl_model[DCR_RETRY_BIT] |=> cfg_retry_cpl_send)
        else $error("enabled timeout gave no retry completion");
    a_fatal_cause: assert property (err_fatal_msg_send |->
        $past(fatal_err_event && ctl_model[DCR_FATAL_REPORT_BIT]))
        else $error("fatal message without an enabled event");
    a_nonfatal_cause: assert property (err_nonfatal_msg_send |->
        $past((nonfatal_err_event && ctl_model[DCR_NONFATAL_REPORT_BIT])
        || (unsupp_req_rcvd && ctl_model[DCR_UR_REPORT_BIT])))
        else $error("nonfatal message without an enabled event");
    a_cor_cause: assert property (err_cor_msg_send |->
        $past(corr_err_event && ctl_model[DCR_CORR_REPORT_BIT]))
        else $error("correctable message without an enabled event");
    a_cor_send: assert property (corr_err_event && ctl_model[DCR_CORR_REPORT_BIT] |=> err_cor_msg_send)
        else $error("enabled correctable event gave no message");
    a_snoop_vc: assert property (tlp_no_snoop |->
        $past(upstream_vc_nonzero && ctl_model[DCR_NO_SNOOP_BIT]))
        else $error("no snoop set for channel zero traffic or while disabled");
    a_aux_store: assert property (aux_power_pm_en == ctl_model[DCR_AUX_PM_BIT])
        else $error("aux power enable differs from the written bit");
    a_ro_bits: assert property (reg_read && reg_addr == DCR_DEV_CTL_ADDR |=> reg_rdata[9:8] == 2'h0 && !reg_rdata[4])
        else $error("unsupported feature bit reads one");
    a_size_codes: assert property ($onehot(payload_limit_bytes) && payload_limit_bytes[6:0] == 7'h00)
        else $error("payload limit is not a legal size");
    a_prefetch_cap: assert property (read_prefetch_bytes <= read_req_limit_bytes)
        else $error("prefetch exceeds read request limit");
endmodule : dcr_checker

bind dcr_device_control dcr_checker CHK (.*);

/* tb/pcie_device_control_reg_tb_top.sv */
module pcie_device_control_reg_tb_top
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn = 0, reg_write = 0, reg_read = 0, upstream_vc_nonzero = 0;
    logic cfg_fwd_timeout = 0, unsupp_req_rcvd = 0, fatal_err_event = 0, nonfatal_err_event = 0, corr_err_event = 0;
    logic [7:0] reg_addr = 8'h00, n_msg;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic cfg_retry_cpl_send, err_fatal_msg_send, err_nonfatal_msg_send, err_cor_msg_send;
    logic tlp_no_snoop, aux_power_pm_en, irq;
    logic [12:0] read_req_limit_bytes, payload_limit_bytes, read_prefetch_bytes;
    int n_mismatch = 0, comparisons = 0;
    // Expected message per event, and the enable bit that gates it.
    localparam logic [3:0] EMAP [5] = '{4'h1, 4'h2, 4'h4, 4'h2, 4'h8};
    localparam int EBIT [5] = '{0, 1, 2, 3, 15};
    wire [3:0] msgs = {cfg_retry_cpl_send, err_fatal_msg_send, err_nonfatal_msg_send, err_cor_msg_send};
    dcr_device_control DUT (.*);
    dcr_rc_model RC (.*);
    // Clock of 8 ns.
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_read <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask : rd
    // Derived limits lag the register by one more cycle, so let two edges pass.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic pulse(input int i);
        @(posedge clk) {cfg_fwd_timeout, unsupp_req_rcvd, fatal_err_event, nonfatal_err_event, corr_err_event} <= 5'(1 << i);
        @(posedge clk) {cfg_fwd_timeout, unsupp_req_rcvd, fatal_err_event, nonfatal_err_event, corr_err_event} <= 5'h00;
        #1;
    endtask : pulse
    task automatic t_fields();
        rd(DCR_DEV_CTL_ADDR, 16'h2800);
        chk("rlim", 16'(read_req_limit_bytes), 16'h0200);
        chk("plim", 16'(payload_limit_bytes), 16'h0080);
        wr(DCR_DEV_CTL_ADDR, 16'hdfbf);
        rd(DCR_DEV_CTL_ADDR, 16'hdcaf);
        settle();
        chk("aux", 16'(aux_power_pm_en), 16'h0001);
        for (int c = 0; c < 6; c++) begin
            wr(DCR_DEV_CTL_ADDR, {1'b0, 3'(c), 4'h0, 3'(c), 5'h00});
            settle();
            chk("rlim", 16'(read_req_limit_bytes), 16'h0080 << c);
            chk("plim", 16'(payload_limit_bytes), 16'h0080 << c);
            chk("pf", 16'(read_prefetch_bytes), 16'h0080 << c);
        end
        wr(DCR_CLS_ADDR, 16'h0008);
        settle();
        chk("pf", 16'(read_prefetch_bytes), 16'h0020);
    endtask : t_fields
    task automatic t_events();
        wr(DCR_DEV_CTL_ADDR, 16'ha80f);
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            chk("msg", 16'(msgs), 16'(EMAP[i]));
            wr(DCR_DEV_CTL_ADDR, 16'ha80f ^ (16'h0001 << EBIT[i]));
            pulse(i);
            chk("msg", 16'(msgs), 16'h0000);
            wr(DCR_DEV_CTL_ADDR, 16'ha80f);
        end
        chk("snoop", 16'(tlp_no_snoop), 16'h0000);
        @(posedge clk) upstream_vc_nonzero <= 1'b1;
        settle();
        chk("snoop", 16'(tlp_no_snoop), 16'h0001);
        wr(DCR_DEV_CTL_ADDR, 16'h0000);
        settle();
        chk("snoop", 16'(tlp_no_snoop), 16'h0000);
    endtask : t_events
    task automatic t_irq();
        rd(DCR_INT_STATUS_ADDR, 16'h001f);
        chk("irq", 16'(irq), 16'h0000);
        wr(DCR_INT_MASK_ADDR, 16'h0001);
        settle();
        chk("irq", 16'(irq), 16'h0001);
        wr(DCR_INT_STATUS_ADDR, 16'h001f);
        settle();
        chk("irq", 16'(irq), 16'h0000);
        rd(DCR_INT_STATUS_ADDR, 16'h0000);
        rd(8'hf0, 16'h0000);
        pulse(0);
        chk("irq", 16'(irq), 16'h0001);
        chk("nmsg", 16'(n_msg), 16'h0005);
    endtask : t_irq
    // Reset in mid-run must restore the defaults, including the derived prefetch.
    task automatic t_reset();
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) resetn <= 1'b1;
        rd(DCR_DEV_CTL_ADDR, 16'h2800);
        chk("pf", 16'(read_prefetch_bytes), 16'h0200);
        chk("irq", 16'(irq), 16'h0000);
    endtask : t_reset
    task automatic stop_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // Main sequence after a two-cycle reset.
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_fields();
        t_events();
        t_irq();
        t_reset();
        stop_test();
    end
    // Watchdog well beyond the hundred or so cycles the run needs.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule : pcie_device_control_reg_tb_top
